// ### hdl/ppfs_top.v
// Notes on behaviour
// - Each logical port carries a 2-bit code naming its physical port 1-4.
// - A remap write that gives one code to two ports is dropped whole.
// - Rank register 27h holds port 1 rank in bits 2:0, port 2 in 6:4.
// - Rank register 28h holds port 3 rank in bits 2:0, port 4 in 6:4.
// - Ranks act on shutdown codes only while 3-bit mode is selected.
// - A code at or below a port's rank powers that port off.
// - A code above a port's rank leaves that port as it is.
// - Rank 000 falls only to code 000 and rank 111 to any code.
// - A rank turn-off acts as a port reset but keeps cool-down running.
`timescale 1ns/1ps
`include "ppfs_defs.vh"

module ppfs_top #(
   parameter NUM_PORTS = 4,
   parameter COOL_CYCLES = `PPFS_COOL_US * `PPFS_CLK_MHZ,
   parameter ADDR_W = 8
) (
   input wire ref_clk_in, // 20 MHz clock
   input wire rst_in, // Synchronous reset, active high
   input wire psel_in, // APB select
   input wire penable_in, // APB enable
   input wire pwrite_in, // APB direction, high for write
   input wire [ADDR_W-1:0] paddr_in, // APB byte address
   input wire [31:0] pwdata_in, // APB write data
   output reg [31:0] prdata_out, // APB read data
   output reg pready_out, // APB ready
   output reg pslverr_out, // APB error, unmapped address
   input wire shutdown_frame_in, // Shutdown frame pin
   input wire shutdown_strobe_in, // Shutdown bit strobe pin
   input wire fast_shutdown_code_input_in, // Shutdown serial data pin
   input wire [NUM_PORTS-1:0] phys_fault_in, // Fault per physical port
   output reg [NUM_PORTS-1:0] phys_power_out // Gate enable per phys port
);

   localparam ST_IDLE = 3'b001;
   localparam ST_POWERED = 3'b010;
   localparam ST_COOLING = 3'b100;
   localparam CNT_W = 32;

   // Register file
   reg [7:0] remap;
   reg [7:0] rank12;
   reg [7:0] rank34;
   reg [7:0] ctrl;

   // Per-port state, gathered from the flip-flops of each port below
   // so that every vector has a single driver
   wire [3*NUM_PORTS-1:0] port_state;
   wire [NUM_PORTS-1:0] fault_flag;
   wire [CNT_W*NUM_PORTS-1:0] cool_cnt;
   reg [`PPFS_CODE_W-1:0] last_code;

   // Fault pin synchronisers
   reg [NUM_PORTS-1:0] fault_meta;
   reg [NUM_PORTS-1:0] fault_sync;

   // Bus decode
   wire [5:0] idx;
   wire aligned;
   wire access;
   wire commit;
   reg mapped;
   reg [7:0] read_data;
   reg next_pready;
   reg next_pslverr;
   reg [31:0] next_prdata;

   // Write strobes, one cycle each
   wire wr_remap;
   wire wr_rank12;
   wire wr_rank34;
   wire wr_ctrl;
   wire wr_power;
   wire wr_reset;
   wire remap_ok;

   // Shutdown code path
   wire code_valid;
   wire [`PPFS_CODE_W-1:0] code;
   wire mode3;
   wire [3*NUM_PORTS-1:0] rank_all;
   wire [2*NUM_PORTS-1:0] remap_all;

   // Per-port decisions
   wire [NUM_PORTS-1:0] powered;
   wire [NUM_PORTS-1:0] cooling;
   wire [NUM_PORTS-1:0] rank_off;
   wire [NUM_PORTS-1:0] port_fault;
   wire [NUM_PORTS-1:0] on_req;
   wire [NUM_PORTS-1:0] rst_req;
   wire [NUM_PORTS-1:0] next_phys;

   function is_perm;
      input [7:0] v;
      begin
         is_perm = (v[1:0] != v[3:2]) && (v[1:0] != v[5:4]) &&
                   (v[1:0] != v[7:6]) && (v[3:2] != v[5:4]) &&
                   (v[3:2] != v[7:6]) && (v[5:4] != v[7:6]);
      end
   endfunction

   ppfs_code_rx i_ppfs_code_rx (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .frame_in(shutdown_frame_in),
      .strobe_in(shutdown_strobe_in),
      .fast_shutdown_code_input_in(fast_shutdown_code_input_in),
      .code_valid_out(code_valid),
      .code_out(code)
   );

   // APB decode. Registers sit at index times four; low bits must be zero.
   assign idx = paddr_in[7:2];
   assign aligned = (paddr_in[1:0] == 2'h0);
   assign access = psel_in & penable_in;
   assign commit = access & pready_out & pwrite_in & ~pslverr_out;

   // Writes land only at the edge where the master sees ready
   assign wr_remap = commit && idx == `PPFS_IDX_REMAP;
   assign wr_rank12 = commit && idx == `PPFS_IDX_RANK12;
   assign wr_rank34 = commit && idx == `PPFS_IDX_RANK34;
   assign wr_ctrl = commit && idx == `PPFS_IDX_CTRL;
   assign wr_power = commit && idx == `PPFS_IDX_POWER;
   assign wr_reset = commit && idx == `PPFS_IDX_RESET;

   // A duplicate code would give one physical port two owners
   assign remap_ok = is_perm(pwdata_in[7:0]);

   // Read mux; unaligned or unknown offsets answer with an error
   always @* begin
      mapped = 1'b1;
      read_data = 8'h00;
      case (idx)
         `PPFS_IDX_REMAP: read_data = remap;
         `PPFS_IDX_RANK12: read_data = rank12;
         `PPFS_IDX_RANK34: read_data = rank34;
         `PPFS_IDX_CTRL: read_data = ctrl;
         `PPFS_IDX_POWER: read_data = {cooling, powered};
         `PPFS_IDX_RESET: read_data = 8'h00;
         `PPFS_IDX_STATUS: read_data = {1'b0, last_code, fault_flag};
         default: mapped = 1'b0;
      endcase
      if (!aligned) begin
         mapped = 1'b0;
      end
   end

   // One wait state: ready rises the cycle after the access phase opens,
   // so read data is already stable when the master samples it.
   always @* begin
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = prdata_out;
      if (access && !pready_out) begin
         next_pready = 1'b1;
         next_pslverr = ~mapped;
         if (mapped && !pwrite_in) begin
            next_prdata = {24'h000000, read_data};
         end else begin
            next_prdata = 32'h00000000;
         end
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
      end else begin
         pready_out <= next_pready;
         pslverr_out <= next_pslverr;
         prdata_out <= next_prdata;
      end
   end

   // Configuration registers
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         remap <= `PPFS_RST_REMAP;
         rank12 <= `PPFS_RST_RANK;
         rank34 <= `PPFS_RST_RANK;
         ctrl <= `PPFS_RST_CTRL;
      end else begin
         if (wr_remap && remap_ok) begin
            remap <= pwdata_in[7:0];
         end
         // Bits 3 and 7 are not kept, so they read back as 0
         if (wr_rank12) begin
            rank12 <= pwdata_in[7:0] & `PPFS_RANK_MASK;
         end
         if (wr_rank34) begin
            rank34 <= pwdata_in[7:0] & `PPFS_RANK_MASK;
         end
         if (wr_ctrl) begin
            ctrl <= {7'h00, pwdata_in[`PPFS_CTRL_MODE3]};
         end
      end
   end

   // Last complete code, kept for software to read back
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         last_code <= {`PPFS_CODE_W{1'b0}};
      end else if (code_valid) begin
         last_code <= code;
      end
   end

   // Fault pins come from outside the clock domain
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         fault_meta <= {NUM_PORTS{1'b0}};
         fault_sync <= {NUM_PORTS{1'b0}};
      end else begin
         fault_meta <= phys_fault_in;
         fault_sync <= fault_meta;
      end
   end

   // Rank fields flattened, logical port 1 in the lowest bits
   assign mode3 = ctrl[`PPFS_CTRL_MODE3];
   assign remap_all = remap;
   assign rank_all = {rank34[`PPFS_RANK_HI+2:`PPFS_RANK_HI],
                      rank34[`PPFS_RANK_LO+2:`PPFS_RANK_LO],
                      rank12[`PPFS_RANK_HI+2:`PPFS_RANK_HI],
                      rank12[`PPFS_RANK_LO+2:`PPFS_RANK_LO]};

   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
         wire [1:0] phys_sel;
         wire [2:0] rank;
         wire [2:0] state;
         wire [CNT_W-1:0] cnt;
         reg [2:0] next_state;
         reg [CNT_W-1:0] next_cnt;
         reg [2:0] state_q;
         reg [CNT_W-1:0] cnt_q;
         reg flag_q;
         reg phys_on;
         integer l;

         assign phys_sel = remap_all[2*g+1:2*g];
         assign rank = rank_all[3*g+2:3*g];
         assign port_state[3*g+2:3*g] = state_q;
         assign cool_cnt[CNT_W*g+CNT_W-1:CNT_W*g] = cnt_q;
         assign fault_flag[g] = flag_q;
         assign state = state_q;
         assign cnt = cnt_q;

         assign powered[g] = (state == ST_POWERED);
         assign cooling[g] = (state == ST_COOLING);
         // Fault seen on the physical port this logical port drives
         assign port_fault[g] = fault_sync[phys_sel];
         // Ranks ignored unless 3-bit mode is on; compare is unsigned,
         // so rank 111 falls to any code and 000 only to 000.
         assign rank_off[g] = code_valid && mode3
                              && (code <= rank);
         // Bus requests address logical ports, one bit each
         assign on_req[g] = wr_power & pwdata_in[g];
         assign rst_req[g] = wr_reset & pwdata_in[g];

         always @* begin
            next_state = state;
            next_cnt = cnt;
            case (state)
               ST_IDLE: begin
                  if (on_req[g] && !rst_req[g] && !rank_off[g]) begin
                     next_state = ST_POWERED;
                  end
               end
               ST_POWERED: begin
                  if (rst_req[g] || rank_off[g]) begin
                     next_state = ST_IDLE;
                  end else if (port_fault[g]) begin
                     next_state = ST_COOLING;
                     next_cnt = COOL_CYCLES;
                  end
               end
               ST_COOLING: begin
                  // A rank turn-off finds the port already off and
                  // leaves the count alone; only a reset cancels it.
                  if (rst_req[g]) begin
                     next_state = ST_IDLE;
                     next_cnt = {CNT_W{1'b0}};
                  end else if (cnt <= 1) begin
                     next_state = ST_IDLE;
                     next_cnt = {CNT_W{1'b0}};
                  end else begin
                     next_cnt = cnt - 1;
                  end
               end
               default: begin
                  next_state = ST_IDLE;
                  next_cnt = {CNT_W{1'b0}};
               end
            endcase
         end

         always @(posedge ref_clk_in) begin
            if (rst_in) begin
               state_q <= ST_IDLE;
               cnt_q <= {CNT_W{1'b0}};
            end else begin
               state_q <= next_state;
               cnt_q <= next_cnt;
            end
         end

         // Fault flag clears as a reset does; a new fault wins the clash
         always @(posedge ref_clk_in) begin
            if (rst_in) begin
               flag_q <= 1'b0;
            end else if (powered[g] && port_fault[g]) begin
               flag_q <= 1'b1;
            end else if (rst_req[g] || rank_off[g]) begin
               flag_q <= 1'b0;
            end
         end

         // Physical port g is driven by whichever logical port names it
         always @* begin
            phys_on = 1'b0;
            for (l = 0; l < NUM_PORTS; l = l + 1) begin
               if ({30'h0, remap_all[2*l+:2]} == g && powered[l]) begin
                  phys_on = 1'b1;
               end
            end
         end
         assign next_phys[g] = phys_on;
      end
   endgenerate

   // Registered so the gate pins never see a decode glitch
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         phys_power_out <= {NUM_PORTS{1'b0}};
      end else begin
         phys_power_out <= next_phys;
      end
   end

endmodule

// ### hdl/ppfs_defs.vh
`ifndef PPFS_DEFS_VH
`define PPFS_DEFS_VH

// Register indices; byte address is four times the index
`define PPFS_IDX_REMAP 6'h26
`define PPFS_IDX_RANK12 6'h27
`define PPFS_IDX_RANK34 6'h28
`define PPFS_IDX_CTRL 6'h29
`define PPFS_IDX_POWER 6'h2a
`define PPFS_IDX_RESET 6'h2b
`define PPFS_IDX_STATUS 6'h2c

// Reset values
`define PPFS_RST_REMAP 8'he4
`define PPFS_RST_RANK 8'h00
`define PPFS_RST_CTRL 8'h00

// Field layout
`define PPFS_RANK_MASK 8'h77
`define PPFS_RANK_LO 0
`define PPFS_RANK_HI 4
`define PPFS_CTRL_MODE3 0
`define PPFS_CODE_W 3

// Timing
`define PPFS_COOL_US 1000
`define PPFS_CLK_MHZ 20

`endif

// ### hdl/ppfs_code_rx.v
`timescale 1ns/1ps
`include "ppfs_defs.vh"

module ppfs_code_rx (
   input wire ref_clk_in, // 20 MHz clock
   input wire rst_in, // Synchronous reset, active high
   input wire frame_in, // Shutdown frame pin, high during a word
   input wire strobe_in, // Bit strobe pin, data taken on rising edge
   input wire fast_shutdown_code_input_in, // Serial code data pin
   output reg code_valid_out, // One-cycle pulse, code complete
   output reg [`PPFS_CODE_W-1:0] code_out // Assembled code, MSB first
);

   reg [1:0] frame_sync;
   reg [1:0] strobe_sync;
   reg [1:0] data_sync;
   reg strobe_last;
   reg [1:0] bit_count;
   reg [`PPFS_CODE_W-1:0] shift;
   wire strobe_rise;

   assign strobe_rise = strobe_sync[1] & ~strobe_last;

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         frame_sync <= 2'h0;
         strobe_sync <= 2'h0;
         data_sync <= 2'h0;
         strobe_last <= 1'b0;
      end else begin
         frame_sync <= {frame_sync[0], frame_in};
         strobe_sync <= {strobe_sync[0], strobe_in};
         data_sync <= {data_sync[0], fast_shutdown_code_input_in};
         strobe_last <= strobe_sync[1];
      end
   end

   // Bits past the third in one frame are dropped until the frame ends
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         bit_count <= 2'h0;
         shift <= {`PPFS_CODE_W{1'b0}};
         code_valid_out <= 1'b0;
         code_out <= {`PPFS_CODE_W{1'b0}};
      end else begin
         code_valid_out <= 1'b0;
         if (!frame_sync[1]) begin
            bit_count <= 2'h0;
         end else if (strobe_rise && bit_count != 2'h3) begin
            shift <= {shift[`PPFS_CODE_W-2:0], data_sync[1]};
            bit_count <= bit_count + 2'h1;
            if (bit_count == 2'h2) begin
               code_valid_out <= 1'b1;
               code_out <= {shift[`PPFS_CODE_W-2:0], data_sync[1]};
            end
         end
      end
   end

endmodule

// ### sim/ppfs_top_chk.sv
`timescale 1ns/1ps
`include "ppfs_defs.vh"

module ppfs_top_chk #(
   parameter NUM_PORTS = 4,
   parameter ADDR_W = 8
) (
   input wire ref_clk_in, // Clock
   input wire rst_in, // Reset
   input wire psel_in, // APB select
   input wire penable_in, // APB enable
   input wire pwrite_in, // APB direction
   input wire [ADDR_W-1:0] paddr_in, // APB address
   input wire [31:0] prdata_out, // APB read data
   input wire pready_out, // APB ready
   input wire pslverr_out, // APB error
   input wire shutdown_frame_in, // Frame pin
   input wire [NUM_PORTS-1:0] phys_fault_in, // Fault pins
   input wire [NUM_PORTS-1:0] phys_power_out // Power enables
);
   localparam [7:0] A_RM = {`PPFS_IDX_REMAP, 2'b00};
   localparam [7:0] A_R12 = {`PPFS_IDX_RANK12, 2'b00};
   localparam [7:0] A_R34 = {`PPFS_IDX_RANK34, 2'b00};
   localparam [7:0] A_HI = {`PPFS_IDX_STATUS, 2'b00};
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   logic [3:0] quiet;
   wire rd = pready_out && !pwrite_in;
   wire bad = paddr_in < A_RM || paddr_in > A_HI || paddr_in[1:0] != 2'b00;
   wire [7:0] m = prdata_out[7:0];
   wire [3:0] used = (4'h1 << m[1:0]) | (4'h1 << m[3:2]) |
      (4'h1 << m[5:4]) | (4'h1 << m[7:6]);
   // Power may only move on a code, a bus write or a fault
   always @(posedge ref_clk_in) begin
      if (rst_in || shutdown_frame_in || psel_in || |phys_fault_in)
         quiet <= 4'h0;
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   end
   sequence s_access;
      psel_in && penable_in && !pready_out;
   endsequence
   AST_ANSWER: assert property (s_access |=> pready_out)
      else $error("ready missing after access phase");
   AST_PULSE: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   AST_ERR: assert property (pready_out |-> pslverr_out == bad)
      else $error("error flag wrong for address");
   AST_ERR_RDY: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   AST_UPPER: assert property (rd |-> prdata_out[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_R12: assert property (rd && paddr_in == A_R12 |-> !m[3] && !m[7])
      else $error("unused rank bit set");
   AST_R34: assert property (rd && paddr_in == A_R34 |-> !m[3] && !m[7])
      else $error("unused rank bit set");
   AST_REMAP: assert property (rd && paddr_in == A_RM |-> used == 4'hf)
      else $error("remap holds a duplicate code");
   AST_QUIET: assert property (quiet >= 4'hc |=> $stable(phys_power_out))
      else $error("power moved without cause");
endmodule

bind ppfs_top ppfs_top_chk #(.NUM_PORTS(NUM_PORTS), .ADDR_W(ADDR_W))
   i_ppfs_top_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .shutdown_frame_in(shutdown_frame_in),
   .phys_fault_in(phys_fault_in), .phys_power_out(phys_power_out));

// ### sim/ppfs_sd_host.sv
`timescale 1ns/1ps

module ppfs_sd_host (
   input wire ref_clk_in, // Clock
   output logic frame_out, // Frame pin
   output logic strobe_out, // Bit strobe pin
   output logic data_out // Serial data pin
);
   initial begin
      frame_out = 1'b0;
      strobe_out = 1'b0;
      data_out = 1'b0;
   end
   // Four clocks per level, above the three the synchroniser needs
   task automatic hold4;
      repeat (4) @(posedge ref_clk_in);
   endtask
   // A short count sends a partial word, which must be dropped
   task automatic send(input logic [2:0] v, input int n);
      frame_out <= 1'b1;
      hold4();
      for (int i = 2; i > 2 - n; i--) begin
         data_out <= v[i];
         hold4();
         strobe_out <= 1'b1;
         hold4();
         strobe_out <= 1'b0;
      end
      hold4();
      frame_out <= 1'b0;
      data_out <= ~data_out;
      hold4();
   endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
`include "ppfs_defs.vh"

module tb;
   localparam [7:0] A_RM = {`PPFS_IDX_REMAP, 2'b00};
   localparam [7:0] A_R12 = {`PPFS_IDX_RANK12, 2'b00};
   localparam [7:0] A_R34 = {`PPFS_IDX_RANK34, 2'b00};
   localparam [7:0] A_CT = {`PPFS_IDX_CTRL, 2'b00};
   localparam [7:0] A_PW = {`PPFS_IDX_POWER, 2'b00};
   localparam [7:0] A_RS = {`PPFS_IDX_RESET, 2'b00};
   localparam [7:0] A_ST = {`PPFS_IDX_STATUS, 2'b00};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rdata;
   logic [3:0] fault = 4'h0;
   logic [3:0] lg;
   logic [2:0] rank [4] = '{3'd0, 3'd5, 3'd7, 3'd3};
   wire [31:0] prdata;
   wire prdy, perr, fr, sb, sd;
   wire [3:0] power;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;

   ppfs_top #(.COOL_CYCLES(200)) i_ppfs_top (.ref_clk_in(clk),
      .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(prdy), .pslverr_out(perr), .shutdown_frame_in(fr),
      .shutdown_strobe_in(sb), .fast_shutdown_code_input_in(sd),
      .phys_fault_in(fault), .phys_power_out(power));
   ppfs_sd_host i_ppfs_sd_host (.ref_clk_in(clk), .frame_out(fr),
      .strobe_out(sb), .data_out(sd));

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic stop_test;
      if (failures == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         $display("ERROR timeout expected done seen running");
         stop_test();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic e);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      rdata = prdata;
      check("pready", {31'h0, prdy}, 32'h1);
      check("pslverr", {31'h0, perr}, {31'h0, e});
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] exp);
      apb(1'b0, a, 8'h00, 1'b0);
      check(nm, rdata, exp);
   endtask

   task automatic code(input logic [2:0] v, input int n);
      i_ppfs_sd_host.send(v, n);
      repeat (4) @(posedge clk);
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc("remap", A_RM, 32'he4);
      rdc("rank12", A_R12, 32'h0);
      rdc("rank34", A_R34, 32'h0);
      apb(1'b0, 8'h04, 8'h00, 1'b1);
      wr(A_R12, 8'hff);
      rdc("rank12", A_R12, 32'h77);
      wr(A_R34, 8'hff);
      rdc("rank34", A_R34, 32'h77);
      wr(A_RM, 8'h00);
      rdc("remap", A_RM, 32'he4);
      wr(A_RM, 8'h1b);
      rdc("remap", A_RM, 32'h1b);
      wr(A_R12, 8'h50);
      wr(A_R34, 8'h37);
      wr(A_PW, 8'h0f);
      code(3'd0, 3);
      check("mode_off", power, 32'hf);
      wr(A_CT, 8'h01);
      for (int c = 0; c < 8; c++) begin
         wr(A_PW, 8'h0f);
         code(c[2:0], 3);
         for (int p = 0; p < 4; p++) lg[p] = rank[p] < c;
         check("power", power, {lg[0], lg[1], lg[2], lg[3]});
         rdc("power_reg", A_PW, {28'h0, lg});
      end
      wr(A_PW, 8'h0f);
      code(3'd0, 2);
      check("partial", power, 32'hf);
      rdc("status", A_ST, 32'h70);
      fault <= 4'h1;
      repeat (6) @(posedge clk);
      fault <= 4'h0;
      rdc("power_reg", A_PW, 32'h87);
      code(3'd0, 3);
      rdc("power_reg", A_PW, 32'h80);
      rdc("status", A_ST, 32'h00);
      wr(A_PW, 8'h08);
      repeat (2) @(posedge clk);
      check("cooling", power, 32'h0);
      repeat (200) @(posedge clk);
      wr(A_PW, 8'h08);
      repeat (2) @(posedge clk);
      check("cooled", power, 32'h1);
      fault <= 4'h1;
      repeat (6) @(posedge clk);
      fault <= 4'h0;
      rdc("power_reg", A_PW, 32'h80);
      rdc("status", A_ST, 32'h08);
      wr(A_RS, 8'h08);
      rdc("power_reg", A_PW, 32'h00);
      rdc("status", A_ST, 32'h00);
      wr(A_PW, 8'h08);
      repeat (2) @(posedge clk);
      check("reset_cancel", power, 32'h1);
      wr(A_RS, 8'h08);
      repeat (2) @(posedge clk);
      check("reset_off", power, 32'h0);
      stop_test();
   end
endmodule
